// [verilog/crg_pkg.sv]
package crg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SYS_RST_NS = 400;
  localparam int SYS_RST_CYC_I = (SYS_RST_NS + CLK_PERIOD_NS - 1) /
                                 CLK_PERIOD_NS;
  localparam logic [4:0] SYS_RST_CYC = 5'(SYS_RST_CYC_I);

  // ----------------------------------------------------------------
  // Register offsets (byte addresses) and counts
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] PLL_OFS = 8'h04;
  localparam logic [7:0] STAT_OFS = 8'h08;
  localparam logic [7:0] CLKCFG_OFS = 8'h40;
  localparam int NUM_GEN = 16;
  localparam int NUM_CLK = 17;
  localparam int NUM_MON = 19;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTRL_RXEN_POS = 0;
  localparam int CTRL_TXEN_POS = 1;
  localparam int CTRL_MON_POS = 4;
  localparam int PLL_MULT_POS = 0;
  localparam int PLL_DIV_POS = 8;
  localparam int PLL_POST_POS = 16;
  localparam int PLL_BYP_POS = 24;
  localparam int PLL_REF_POS = 25;
  localparam int CFG_SEL_POS = 0;
  localparam int CFG_PRE_POS = 4;
  localparam int STAT_SLEEP_POS = 8;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_PLL = 2'b00,
    SRC_RC = 2'b01,
    SRC_EXT = 2'b10
  } src_t;

  typedef struct packed {
    logic [1:0] sel;
    logic [2:0] pre;
  } clk_cfg_t;

  typedef struct packed {
    logic ref_ext;
    logic bypass;
    logic [1:0] post_divide_exponent;
    logic [5:0] div;
    logic [5:0] mult;
  } pll_cfg_t;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam clk_cfg_t CLK_CFG_RST = '{sel: 2'h1, pre: 3'h0};
  localparam pll_cfg_t PLL_CFG_RST = '{ref_ext: 1'b0, bypass: 1'b1,
    post_divide_exponent: 2'h0, div: 6'h01, mult: 6'h01};
  localparam logic [4:0] MON_RST = 5'h00;
  localparam logic [4:0] CAUSE_RST = 5'h01;

endpackage : crg_pkg

// [verilog/crg_reset.sv]
module crg_reset import crg_pkg::*; (
  // Clock and power reset
  input wire logic clk,
  input wire logic rst,
  // Reset sources
  input wire logic ext_pin_n,
  input wire logic wdog_ev,
  input wire logic remap_ev,
  input wire logic core_req,
  // Results
  output logic ext_low,
  output logic sys_rst,
  output logic pwr_rst
);

  logic pin_s1_r;
  logic pin_s2_r;
  logic [4:0] cnt_r;
  logic sys_r;
  logic pwr_r;
  logic evt;

  // ----------------------------------------------------------------
  // Pin synchroniser; the pin is released high at power-up.
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
    end else begin
      pin_s1_r <= ext_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  assign ext_low = ~pin_s2_r;
  assign evt = wdog_ev | remap_ev | core_req;

  // A stretch counter keeps short events wide enough for every block.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 5'h00;
    end else if (ext_low | evt) begin
      cnt_r <= SYS_RST_CYC;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r - 5'h01;
    end
  end

  // System reset; power reset forces it too.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sys_r <= 1'b1;
    end else begin
      sys_r <= ext_low | evt | (cnt_r != 5'h00);
    end
  end

  // Power reset output stays high one edge past the release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr_r <= 1'b1;
    end else begin
      pwr_r <= 1'b0;
    end
  end

  assign sys_rst = sys_r;
  assign pwr_rst = pwr_r;

  property p_evt_stretch;
    @(posedge clk) disable iff (rst) evt |=> sys_r [*8];
  endproperty
  a_evt_stretch: assert property (p_evt_stretch)
    else $error("System reset not stretched after an event.");

  property p_pin_reset;
    @(posedge clk) disable iff (rst) ext_low |=> sys_r;
  endproperty
  a_pin_reset: assert property (p_pin_reset)
    else $error("Low reset pin did not raise system reset.");

  property p_release;
    @(posedge clk) disable iff (rst)
      $fell(sys_r) |-> $past(pwr_r) || $past(cnt_r, 2) == 5'h01;
  endproperty
  a_release: assert property (p_release)
    else $error("System reset released before the stretch ended.");

endmodule : crg_reset

// [verilog/clk_gen.sv]
module clk_gen import crg_pkg::*; #(
  parameter bit FAST = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Source edges: PLL, RC, external oscillator
  input wire logic [2:0] src_ev,
  // Configuration and gate
  input wire clk_cfg_t cfg_req,
  input wire logic gate,
  // Generated clock
  output logic clk_out
);

  clk_cfg_t cfg_r;
  clk_cfg_t cfg_eff;
  logic [6:0] cnt_r;
  logic [6:0] lim;
  logic out_r;
  logic ev;
  logic load;
  logic hold;

  // Fast clocks only offer the four smallest ratios.
  assign cfg_eff = '{sel: cfg_req.sel,
    pre: FAST ? {1'b0, cfg_req.pre[1:0]} : cfg_req.pre};
  assign lim = 7'((8'h01 << cfg_r.pre) - 8'h01);

  // Source mux; the spare code falls back to the PLL.
  always_comb begin
    unique case (cfg_r.sel)
      SRC_RC: ev = src_ev[1];
      SRC_EXT: ev = src_ev[2];
      default: ev = src_ev[0];
    endcase
  end

  // New settings are taken only while low with the count at rest, so a
  // switch never cuts a high phase short; the cost is one period of delay.
  assign load = ~out_r & (cnt_r == 7'h00) & (cfg_r != cfg_eff);
  assign hold = gate & ~out_r;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_r <= CLK_CFG_RST;
    end else if (load) begin
      cfg_r <= cfg_eff;
    end
  end

  // Each source edge counts; the output toggles every 2^pre edges.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r <= 7'h00;
      out_r <= 1'b0;
    end else if (load) begin
      cnt_r <= 7'h00;
    end else if (ev & ~hold) begin
      if (cnt_r == lim) begin
        cnt_r <= 7'h00;
        out_r <= ~out_r;
      end else begin
        cnt_r <= cnt_r + 7'h01;
      end
    end
  end

  assign clk_out = out_r;

  property p_cfg_low;
    @(posedge clk) disable iff (rst)
      (cfg_r != $past(cfg_r)) |-> (!out_r && $past(out_r) == 1'b0);
  endproperty
  a_cfg_low: assert property (p_cfg_low)
    else $error("Clock setting changed during a high phase.");

  property p_edge_cause;
    @(posedge clk) disable iff (rst)
      (out_r != $past(out_r)) |-> $past(ev);
  endproperty
  a_edge_cause: assert property (p_edge_cause)
    else $error("Output toggled without a selected source edge.");

  property p_gate_low;
    @(posedge clk) disable iff (rst) (gate && !out_r) |=> !out_r;
  endproperty
  a_gate_low: assert property (p_gate_low)
    else $error("Gated clock rose.");

  property p_div_one;
    @(posedge clk) disable iff (rst)
      (cfg_r.pre == 3'h0 && ev && !hold && !load) |=> $changed(out_r);
  endproperty
  a_div_one: assert property (p_div_one)
    else $error("Divide by one missed a source edge.");

endmodule : clk_gen

// [verilog/crg_top.sv]
// What this block does
// - Three resets: pin, power, system.
// - Low reset pin asserts external reset.
// - Power-on reset restores every register.
// - Watchdog, remap or core request reset system.
// - System reset spares these and remap registers.
// - Register picks PLL reference: external or RC.
// - PLL takes 8-24 MHz (sampling resolves only below 20 MHz); bypass passes reference.
// - Output equals input times M/N/2^exponent.
// - Each clock selects PLL, RC or external.
// - Fast clocks divide by 1, 2, 4, 8.
// - Slow clocks divide by powers up to 128.
// - Random clock comes straight from PLL.
// - Converter and random clocks stop in sleep.
// - Network clocks come from pads, gateable.
// - Any produced clock selectable for monitoring.
//
// The AXI4-Lite slave port and the register addresses are this design's own decisions.
module crg_top import crg_pkg::*; (
  // Clock and power-on reset
  input wire logic CLK,
  input wire logic RST,
  // Reset sources and sleep
  input wire logic EXTERNAL_RESET_PIN_N,
  input wire logic WATCHDOG_EVENT,
  input wire logic REMAP_DONE,
  input wire logic CORE_RESET_REQUEST,
  input wire logic SLEEP,
  // Clock sources and pads
  input wire logic EXTERNAL_OSCILLATOR_CLOCK,
  input wire logic RC_OSC_CLOCK,
  input wire logic NET_RX_PAD,
  input wire logic NET_TX_PAD,
  // AXI4-Lite slave
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // Generated clocks
  output logic SYSTEM_CLOCK,
  output logic CONVERTER_CLOCK,
  output logic SYNC_SERIAL_CLOCK,
  output logic ASYNC_SERIAL_CLOCK,
  output logic TIMER0_CLOCK,
  output logic TIMER1_CLOCK,
  output logic [7:0] PULSE_WIDTH_CLOCKS,
  output logic CALENDAR_CLOCK,
  output logic WATCHDOG_CLOCK,
  output logic RANDOM_GEN_CLOCK,
  output logic NET_RX_CLOCK,
  output logic NET_TX_CLOCK,
  output logic MONITOR_CLOCK,
  // Resets
  output logic SYSTEM_RESET,
  output logic POWER_RESET
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  pll_cfg_t pll_r;
  clk_cfg_t cfg_r [NUM_GEN];
  logic [1:0] net_en_r;
  logic [4:0] mon_r;
  logic [4:0] cause_r;
  logic [4:0] cause_set;
  logic [4:0] cause_clr;
  logic ext_low;
  logic [1:0] osc_s1_r, osc_s2_r, osc_s3_r;
  logic rc_ev, ext_ev, ref_ev, pll_tick, pll_ev;
  logic [8:0] pll_acc_r;
  logic [9:0] pll_sum;
  logic [8:0] pll_lim;
  logic [5:0] div_eff;
  logic [NUM_CLK-1:0] gen_clk;
  logic [1:0] net_s1_r, net_s2_r, net_gate_r, net_out_r;
  logic [NUM_MON-1:0] mon_vec;
  logic mon_out_r;
  logic aw_rdy_r, w_rdy_r, bvalid_r, ar_rdy_r, rvalid_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, wmask_r, rdata_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_go;
  logic [31:0] rd_word;
  logic rd_hit;

  // ----------------------------------------------------------------
  // Resets
  // ----------------------------------------------------------------
  // The registers here use RST only, so a system reset leaves them.
  crg_reset u_reset (
    .clk(CLK),
    .rst(RST),
    .ext_pin_n(EXTERNAL_RESET_PIN_N),
    .wdog_ev(WATCHDOG_EVENT),
    .remap_ev(REMAP_DONE),
    .core_req(CORE_RESET_REQUEST),
    .ext_low(ext_low),
    .sys_rst(SYSTEM_RESET),
    .pwr_rst(POWER_RESET)
  );

  // Sticky reset causes: power, pin, watchdog, remap, core.
  assign cause_set = {CORE_RESET_REQUEST, REMAP_DONE, WATCHDOG_EVENT,
                      ext_low, 1'b0};
  assign cause_clr = (wr_go && waddr_r == STAT_OFS) ?
                     (wdata_r[4:0] & wmask_r[4:0]) : 5'h00;

  // A cause arriving with its clear is kept.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      cause_r <= CAUSE_RST;
    end else begin
      cause_r <= (cause_r & ~cause_clr) | cause_set;
    end
  end

  // ----------------------------------------------------------------
  // Oscillator and pad sampling
  // ----------------------------------------------------------------
  // Sources are pins; a third flop gives both-edge events. Sampling at
  // 40 MHz resolves sources only below 20 MHz.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      osc_s1_r <= 2'h0;
      osc_s2_r <= 2'h0;
      osc_s3_r <= 2'h0;
    end else begin
      osc_s1_r <= {EXTERNAL_OSCILLATOR_CLOCK, RC_OSC_CLOCK};
      osc_s2_r <= osc_s1_r;
      osc_s3_r <= osc_s2_r;
    end
  end

  assign rc_ev = osc_s2_r[0] ^ osc_s3_r[0];
  assign ext_ev = osc_s2_r[1] ^ osc_s3_r[1];
  assign ref_ev = pll_r.ref_ext ? ext_ev : rc_ev;

  // ----------------------------------------------------------------
  // PLL model
  // ----------------------------------------------------------------
  // A rate accumulator adds M per reference edge and spends N*OD per
  // output edge. Output is capped at one edge per cycle; excess is lost.
  assign div_eff = (pll_r.div == 6'h00) ? 6'h01 : pll_r.div;
  assign pll_lim = 9'({3'h0, div_eff} << (2'h2 *
                   pll_r.post_divide_exponent[1] +
                   {1'b0, pll_r.post_divide_exponent[0]}));
  assign pll_sum = {1'b0, pll_acc_r} + (ref_ev ? {4'h0, pll_r.mult} :
                   10'h000);
  assign pll_tick = pll_sum >= {1'b0, pll_lim};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pll_acc_r <= 9'h000;
    end else if (pll_tick) begin
      pll_acc_r <= (pll_sum - {1'b0, pll_lim} >= {1'b0, pll_lim}) ?
                   pll_lim - 9'h001 : 9'(pll_sum - {1'b0, pll_lim});
    end else begin
      pll_acc_r <= pll_sum[8:0];
    end
  end

  assign pll_ev = pll_r.bypass ? ref_ev : pll_tick;

  // ----------------------------------------------------------------
  // Generated clocks
  // ----------------------------------------------------------------
  // Index 0-3 fast, 4-15 slow, 16 random (fixed PLL, no divider).
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CLK; gi++) begin : g_clk
      clk_gen #(.FAST(gi < 4)) u_gen (
        .clk(CLK),
        .rst(RST),
        .src_ev({ext_ev, rc_ev, pll_ev}),
        .cfg_req(gi == NUM_GEN ? clk_cfg_t'({SRC_PLL, 3'h0}) :
                 cfg_r[gi % NUM_GEN]),
        .gate((gi == 1 || gi == NUM_GEN) ? SLEEP : 1'b0),
        .clk_out(gen_clk[gi])
      );
    end
  endgenerate

  assign SYSTEM_CLOCK = gen_clk[0];
  assign CONVERTER_CLOCK = gen_clk[1];
  assign SYNC_SERIAL_CLOCK = gen_clk[2];
  assign ASYNC_SERIAL_CLOCK = gen_clk[3];
  assign TIMER0_CLOCK = gen_clk[4];
  assign TIMER1_CLOCK = gen_clk[5];
  assign PULSE_WIDTH_CLOCKS = gen_clk[13:6];
  assign CALENDAR_CLOCK = gen_clk[14];
  assign WATCHDOG_CLOCK = gen_clk[15];
  assign RANDOM_GEN_CLOCK = gen_clk[16];

  // ----------------------------------------------------------------
  // Network pad clocks
  // ----------------------------------------------------------------
  // The enable is taken only while the pad is low, so no runt escapes.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      net_s1_r <= 2'h0;
      net_s2_r <= 2'h0;
      net_gate_r <= 2'h0;
      net_out_r <= 2'h0;
    end else begin
      net_s1_r <= {NET_TX_PAD, NET_RX_PAD};
      net_s2_r <= net_s1_r;
      net_gate_r <= (net_en_r & ~net_s2_r) | (net_gate_r & net_s2_r);
      net_out_r <= net_gate_r & net_s2_r;
    end
  end

  assign NET_RX_CLOCK = net_out_r[0];
  assign NET_TX_CLOCK = net_out_r[1];

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  assign mon_vec = {net_out_r, gen_clk};

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      mon_out_r <= 1'b0;
    end else begin
      mon_out_r <= (mon_r < 5'(NUM_MON)) ? mon_vec[mon_r] : 1'b0;
    end
  end

  assign MONITOR_CLOCK = mon_out_r;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign wr_go = ~aw_rdy_r & ~w_rdy_r & ~bvalid_r;

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      aw_rdy_r <= 1'b1;
      w_rdy_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0;
      wmask_r <= 32'h0;
    end else begin
      if (aw_rdy_r && S_AXI_AWVALID) begin
        aw_rdy_r <= 1'b0;
        waddr_r <= {S_AXI_AWADDR[7:2], 2'b00};
      end
      if (w_rdy_r && S_AXI_WVALID) begin
        w_rdy_r <= 1'b0;
        wdata_r <= S_AXI_WDATA;
        for (int b = 0; b < 4; b++) begin
          wmask_r[8*b +: 8] <= {8{S_AXI_WSTRB[b]}};
        end
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= (waddr_r <= STAT_OFS || waddr_r >= CLKCFG_OFS) ?
                   2'b00 : 2'b10;
      end else if (bvalid_r && S_AXI_BREADY) begin
        bvalid_r <= 1'b0;
        aw_rdy_r <= 1'b1;
        w_rdy_r <= 1'b1;
      end
    end
  end

  // Configuration registers; byte strobes merge into the old value.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      pll_r <= PLL_CFG_RST;
      net_en_r <= 2'h0;
      mon_r <= MON_RST;
      for (int i = 0; i < NUM_GEN; i++) begin
        cfg_r[i] <= CLK_CFG_RST;
      end
    end else if (wr_go) begin
      if (waddr_r == CTRL_OFS) begin
        if (wmask_r[0]) begin
          net_en_r <= wdata_r[CTRL_TXEN_POS:CTRL_RXEN_POS];
          mon_r[3:0] <= wdata_r[CTRL_MON_POS +: 4];
        end
        if (wmask_r[8]) begin
          mon_r[4] <= wdata_r[CTRL_MON_POS + 4];
        end
      end
      if (waddr_r == PLL_OFS) begin
        if (wmask_r[0]) pll_r.mult <= wdata_r[PLL_MULT_POS +: 6];
        if (wmask_r[8]) pll_r.div <= wdata_r[PLL_DIV_POS +: 6];
        if (wmask_r[16]) begin
          pll_r.post_divide_exponent <= wdata_r[PLL_POST_POS +: 2];
        end
        if (wmask_r[24]) begin
          pll_r.bypass <= wdata_r[PLL_BYP_POS];
          pll_r.ref_ext <= wdata_r[PLL_REF_POS];
        end
      end
      if (waddr_r >= CLKCFG_OFS && wmask_r[0]) begin
        cfg_r[waddr_r[5:2]] <= '{sel: wdata_r[CFG_SEL_POS +: 2],
                                 pre: wdata_r[CFG_PRE_POS +: 3]};
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    if (S_AXI_ARADDR >= CLKCFG_OFS) begin
      rd_word[CFG_SEL_POS +: 2] = cfg_r[S_AXI_ARADDR[5:2]].sel;
      rd_word[CFG_PRE_POS +: 3] = cfg_r[S_AXI_ARADDR[5:2]].pre;
    end else if (S_AXI_ARADDR[7:2] == CTRL_OFS[7:2]) begin
      rd_word[CTRL_TXEN_POS:CTRL_RXEN_POS] = net_en_r;
      rd_word[CTRL_MON_POS +: 5] = mon_r;
    end else if (S_AXI_ARADDR[7:2] == PLL_OFS[7:2]) begin
      rd_word[PLL_MULT_POS +: 6] = pll_r.mult;
      rd_word[PLL_DIV_POS +: 6] = pll_r.div;
      rd_word[PLL_POST_POS +: 2] = pll_r.post_divide_exponent;
      rd_word[PLL_BYP_POS] = pll_r.bypass;
      rd_word[PLL_REF_POS] = pll_r.ref_ext;
    end else if (S_AXI_ARADDR[7:2] == STAT_OFS[7:2]) begin
      rd_word[4:0] = cause_r;
      rd_word[STAT_SLEEP_POS] = SLEEP;
    end else begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= 2'h0;
    end else if (ar_rdy_r && S_AXI_ARVALID) begin
      ar_rdy_r <= 1'b0;
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? 2'b00 : 2'b10;
    end else if (rvalid_r && S_AXI_RREADY) begin
      ar_rdy_r <= 1'b1;
      rvalid_r <= 1'b0;
    end
  end

  assign S_AXI_AWREADY = aw_rdy_r;
  assign S_AXI_WREADY = w_rdy_r;
  assign S_AXI_BVALID = bvalid_r;
  assign S_AXI_BRESP = bresp_r;
  assign S_AXI_ARREADY = ar_rdy_r;
  assign S_AXI_RVALID = rvalid_r;
  assign S_AXI_RDATA = rdata_r;
  assign S_AXI_RRESP = rresp_r;

  property p_cause_kept;
    @(posedge CLK) disable iff (RST)
      (cause_set[2] && cause_clr[2]) |=> cause_r[2];
  endproperty
  a_cause_kept: assert property (p_cause_kept)
    else $error("Watchdog cause lost under a clear.");

  property p_sys_spares;
    @(posedge CLK) disable iff (RST)
      (SYSTEM_RESET && !wr_go) |=> $stable(pll_r) && $stable(mon_r);
  endproperty
  a_sys_spares: assert property (p_sys_spares)
    else $error("System reset disturbed clock settings.");

  property p_bypass;
    @(posedge CLK) disable iff (RST)
      (pll_r.bypass && ref_ev) |-> pll_ev;
  endproperty
  a_bypass: assert property (p_bypass)
    else $error("Bypass dropped a reference edge.");

  property p_rd_hold;
    @(posedge CLK) disable iff (RST)
      (rvalid_r && !S_AXI_RREADY) |=> rvalid_r && $stable(rdata_r);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("Read data changed before it was taken.");

endmodule : crg_top

// [tb/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import crg_pkg::*;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic CLK = 1'b0, RST = 1'b1, SLEEP = 1'b0;
  logic [3:0] ev = 4'h0;
  logic [7:0] cnt = 8'h00, awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sysrst, pwrrst;
  logic [1:0] bresp, rresp, r;
  logic [19:0] clks;
  int bad_count = 0, tests_run = 0;

  // Half period of the 25 ns clock.
  always #12.5 CLK = ~CLK;

  // Source clocks stay well under half the sampling rate so none is lost.
  always @(posedge CLK) cnt <= cnt + 8'h01;

  crg_top dut (.CLK(CLK), .RST(RST), .EXTERNAL_RESET_PIN_N(~ev[0]),
    .WATCHDOG_EVENT(ev[1]), .REMAP_DONE(ev[2]), .CORE_RESET_REQUEST(ev[3]),
    .SLEEP(SLEEP), .EXTERNAL_OSCILLATOR_CLOCK(cnt[3]),
    .RC_OSC_CLOCK(cnt[2]), .NET_RX_PAD(cnt[2]), .NET_TX_PAD(cnt[3]),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf), .S_AXI_WVALID(wvalid),
    .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid),
    .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .SYSTEM_CLOCK(clks[0]),
    .CONVERTER_CLOCK(clks[1]), .SYNC_SERIAL_CLOCK(clks[7]),
    .ASYNC_SERIAL_CLOCK(clks[8]), .TIMER0_CLOCK(clks[2]),
    .TIMER1_CLOCK(clks[9]), .PULSE_WIDTH_CLOCKS(clks[17:10]),
    .CALENDAR_CLOCK(clks[18]), .WATCHDOG_CLOCK(clks[19]),
    .RANDOM_GEN_CLOCK(clks[3]),
    .NET_RX_CLOCK(clks[4]), .NET_TX_CLOCK(clks[5]), .MONITOR_CLOCK(clks[6]),
    .SYSTEM_RESET(sysrst), .POWER_RESET(pwrrst));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      bad_count++;
      $display("mismatch at %0t: saw %h wanted %h", $time, s, e);
    end
  endtask : chk

  // A wait that runs out of cycles ends the run as a failure.
  task automatic tmo;
    bad_count++;
    $display("mismatch at %0t: wait timed out", $time);
    test_done();
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (awready && awvalid) awvalid <= 1'b0;
      if (wready && wvalid) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        r = bresp;
        bready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge CLK);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int i = 0; i < 50; i++) begin
      @(posedge CLK);
      if (arready && arvalid) arvalid <= 1'b0;
      if (rvalid === 1'b1) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        return;
      end
    end
    tmo();
  endtask : rd

  // Rising edges of one watched clock over n cycles, sampled at CLK.
  task automatic edges(input int k, input int n, output int c);
    logic p = clks[k];
    c = 0;
    repeat (n) begin
      @(posedge CLK);
      if (clks[k] === 1'b1 && p === 1'b0) c++;
      p = clks[k];
    end
  endtask : edges

  // Edge counts may slip by one against the sampling phase.
  task automatic near(input int s, input int e);
    chk({31'h0, s >= e - 1 && s <= e + 1}, 32'h1);
  endtask : near

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    logic [31:0] d;
    int c;
    rd(PLL_OFS, d);
    chk(d, 32'h0100_0101);
    rd(STAT_OFS, d);
    chk(d, 32'h1);
    rd(CLKCFG_OFS, d);
    chk(d, 32'h1);
    rd(8'h0c, d);
    chk({30'h0, r}, 32'h2);
    chk(d, 32'h0);
    // Every clock still at its reset setting runs at the RC rate.
    for (int k = 7; k < 20; k++) begin
      edges(k, 64, c);
      near(c, 8);
    end
    $display("done reset values");
  endtask : t_reset

  task automatic t_sysrst;
    logic [31:0] d;
    wr(CLKCFG_OFS, 32'h12);
    wr(8'h10, 32'h5);
    chk({30'h0, r}, 32'h2);
    for (int i = 0; i < 4; i++) begin
      @(posedge CLK) ev <= 4'h1 << i;
      @(posedge CLK) ev <= 4'h0;
      for (int j = 0; sysrst !== 1'b1; j++) begin
        if (j > 6) tmo();
        @(posedge CLK);
      end
      chk({31'h0, pwrrst}, 32'h0);
      for (int j = 0; sysrst !== 1'b0; j++) begin
        if (j > 40) tmo();
        @(posedge CLK);
      end
    end
    rd(CLKCFG_OFS, d);
    chk(d, 32'h12);
    rd(STAT_OFS, d);
    chk(d, 32'h1f);
    wr(STAT_OFS, 32'h1f);
    rd(STAT_OFS, d);
    chk(d, 32'h0);
    $display("done system reset");
  endtask : t_sysrst

  task automatic t_div;
    int c;
    for (int p = 0; p < 4; p++) begin
      wr(CLKCFG_OFS, 32'h1 | (p << 4));
      repeat (200) @(posedge CLK);
      edges(0, 256, c);
      near(c, 32 >> p);
    end
    wr(CLKCFG_OFS + 8'h10, 32'h41);
    repeat (300) @(posedge CLK);
    edges(2, 512, c);
    near(c, 4);
    $display("done prescalers");
  endtask : t_div

  task automatic t_sleep;
    int c;
    @(posedge CLK) SLEEP <= 1'b1;
    repeat (20) @(posedge CLK);
    edges(1, 256, c);
    chk(c, 0);
    edges(3, 256, c);
    chk(c, 0);
    @(posedge CLK) SLEEP <= 1'b0;
    repeat (20) @(posedge CLK);
    edges(1, 256, c);
    chk({31'h0, c > 0}, 32'h1);
    edges(3, 256, c);
    near(c, 32);
    // External reference times three, over one and over four.
    wr(PLL_OFS, 32'h0202_0103);
    repeat (50) @(posedge CLK);
    edges(3, 256, c);
    near(c, 12);
    $display("done sleep");
  endtask : t_sleep

  task automatic t_net;
    int c;
    edges(4, 256, c);
    chk(c, 0);
    wr(CTRL_OFS, 32'h113);
    repeat (10) @(posedge CLK);
    edges(4, 256, c);
    near(c, 32);
    edges(5, 256, c);
    near(c, 16);
    // Select 17 shows the receive clock.
    edges(6, 256, c);
    near(c, 32);
    $display("done network clocks");
  endtask : t_net

  // Main sequence: reset for three cycles, then each scenario in turn.
  initial begin
    repeat (3) @(posedge CLK);
    RST <= 1'b0;
    t_reset();
    t_sysrst();
    t_div();
    t_sleep();
    t_net();
    test_done();
  end

endmodule : testbench
